// ---- tsbr_defines.svh ----
`ifndef TSBR_DEFINES_SVH
`define TSBR_DEFINES_SVH

// Register byte addresses on the APB
`define TSBR_ADDR_BTE 12'h000
`define TSBR_ADDR_ADJ 12'h004
`define TSBR_ADDR_LIT 12'h008
`define TSBR_ADDR_CTRL 12'h00C

// Reset values
`define TSBR_RST_BTE 16'h0000
`define TSBR_RST_ADJ 16'h0000
`define TSBR_RST_LIT 16'h0000

// Broadcast enable field positions
`define TSBR_BTE_ADC_LSB 12
`define TSBR_BTE_IC_LSB 8
`define TSBR_BTE_OCCLK_LSB 4
`define TSBR_BTE_OCTRG_LSB 0

// Control register bit positions
`define TSBR_CTRL_EN_BIT 0
`define TSBR_CTRL_START_BIT 1

`endif

// ---- tsbr_pkg.sv ----
package tsbr_pkg;

  typedef struct packed {
    logic [3:0] adcTrig;
    logic [3:0] capTrig;
    logic [3:0] cmpClk;
    logic [3:0] cmpTrig;
  } tsbr_pulses_s;

  typedef enum logic [1:0] {
    TSBR_SEL_NONE = 2'b00,
    TSBR_SEL_BTE = 2'b01,
    TSBR_SEL_ADJ = 2'b10,
    TSBR_SEL_LIT = 2'b11
  } tsbr_sel_e;

endpackage

// ---- tsbr_word_reg.sv ----
`timescale 1ns/1ps
`default_nettype none

// One 16-bit software register with a write-lock
module tsbr_word_reg #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic wrLock,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (wrEn && !wrLock) begin
      value_next = wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule // tsbr_word_reg

`default_nettype wire

// ---- tsbr_regs.sv ----
//
// Function
// - Four bits enable ADC sample trigger pulses
// - Four bits enable capture trigger pulses
// - Four bits enable compare clock pulses
// - Four bits enable compare trigger pulses
// - Adjust register supplies value for add command
// - Literal register feeds step command to channel select
// - Writes to the three data registers ignored while enabled and started; control stays writable
//
`timescale 1ns/1ps
`default_nettype none
`include "tsbr_defines.svh"

module tsbr_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic broadcastCmd,
  input wire logic addAdjustCmd,
  input wire logic controlStepCmd,
  output tsbr_pkg::tsbr_pulses_s pulses,
  output logic [15:0] stepAdjustValue,
  output logic addAdjustValid,
  output logic [15:0] adcChannelSelect,
  output logic adcChannelSelectWr,
  output logic sequencerEnable,
  output logic sequencerStart
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic tsbr_pkg::tsbr_sel_e decodeSel(input logic [11:0] a);
    unique case (a)
      `TSBR_ADDR_BTE: decodeSel = tsbr_pkg::TSBR_SEL_BTE;
      `TSBR_ADDR_ADJ: decodeSel = tsbr_pkg::TSBR_SEL_ADJ;
      `TSBR_ADDR_LIT: decodeSel = tsbr_pkg::TSBR_SEL_LIT;
      default: decodeSel = tsbr_pkg::TSBR_SEL_NONE;
    endcase
  endfunction

  tsbr_pkg::tsbr_sel_e sel;
  logic isCtrl;
  logic access;
  logic wrAccess;
  logic locked;
  logic pready_reg;
  logic [15:0] bteVal;
  logic [15:0] adjVal;
  logic [15:0] litVal;

  assign sel = decodeSel(paddr);
  assign isCtrl = (paddr == `TSBR_ADDR_CTRL);
  // One wait state; a write lands only at the edge that ends the access,
  // so a master that aborts early never leaves a half-done write behind
  assign access = psel && penable;
  assign wrAccess = access && pwrite && pready_reg;

  // ----------------------------------------------------------------
  // Control bits and lock
  // ----------------------------------------------------------------
  logic enable_reg;
  logic enable_next;
  logic start_reg;
  logic start_next;

  always_comb begin
    enable_next = enable_reg;
    start_next = start_reg;
    if (wrAccess && isCtrl) begin
      enable_next = pwdata[`TSBR_CTRL_EN_BIT];
      start_next = pwdata[`TSBR_CTRL_START_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      start_reg <= start_next;
    end
  end

  assign locked = enable_reg && start_reg;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  tsbr_word_reg #(.WIDTH(16), .RESET_VAL(`TSBR_RST_BTE)) u_bte (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrAccess && sel == tsbr_pkg::TSBR_SEL_BTE),
    .wrLock(locked),
    .wrData(pwdata[15:0]),
    .value(bteVal)
  );

  tsbr_word_reg #(.WIDTH(16), .RESET_VAL(`TSBR_RST_ADJ)) u_adj (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrAccess && sel == tsbr_pkg::TSBR_SEL_ADJ),
    .wrLock(locked),
    .wrData(pwdata[15:0]),
    .value(adjVal)
  );

  tsbr_word_reg #(.WIDTH(16), .RESET_VAL(`TSBR_RST_LIT)) u_lit (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(wrAccess && sel == tsbr_pkg::TSBR_SEL_LIT),
    .wrLock(locked),
    .wrData(pwdata[15:0]),
    .value(litVal)
  );

  // ----------------------------------------------------------------
  // APB read path and answer
  // ----------------------------------------------------------------
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  // Registered answer: pready rises one cycle into the access phase
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (access && !pready_reg) begin
      pready_next = 1'b1;
      pslverr_next = (sel == tsbr_pkg::TSBR_SEL_NONE) && !isCtrl;
      prdata_next = 32'h0000_0000;
      if (!pwrite) begin
        unique case (sel)
          tsbr_pkg::TSBR_SEL_BTE: prdata_next = {16'h0000, bteVal};
          tsbr_pkg::TSBR_SEL_ADJ: prdata_next = {16'h0000, adjVal};
          tsbr_pkg::TSBR_SEL_LIT: prdata_next = {16'h0000, litVal};
          tsbr_pkg::TSBR_SEL_NONE: begin
            if (isCtrl) begin
              prdata_next = {30'h0000_0000, start_reg, enable_reg};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ----------------------------------------------------------------
  // Broadcast pulses and command data
  // ----------------------------------------------------------------
  tsbr_pkg::tsbr_pulses_s pulses_reg;
  tsbr_pkg::tsbr_pulses_s pulses_next;
  logic [15:0] chanSel_reg;
  logic [15:0] chanSel_next;
  logic chanWr_reg;
  logic chanWr_next;
  logic [15:0] adjOut_reg;
  logic addValid_reg;

  always_comb begin
    pulses_next = '0;
    if (broadcastCmd) begin
      pulses_next.adcTrig = bteVal[`TSBR_BTE_ADC_LSB +: 4];
      pulses_next.capTrig = bteVal[`TSBR_BTE_IC_LSB +: 4];
      pulses_next.cmpClk = bteVal[`TSBR_BTE_OCCLK_LSB +: 4];
      pulses_next.cmpTrig = bteVal[`TSBR_BTE_OCTRG_LSB +: 4];
    end
    chanSel_next = chanSel_reg;
    chanWr_next = controlStepCmd;
    if (controlStepCmd) begin
      chanSel_next = litVal;
    end
  end

  // All pulses come from one register, so they rise together and stay high one cycle for each cycle of broadcastCmd
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulses_reg <= '0;
      chanSel_reg <= 16'h0000;
      chanWr_reg <= 1'b0;
      adjOut_reg <= 16'h0000;
      addValid_reg <= 1'b0;
    end else begin
      pulses_reg <= pulses_next;
      chanSel_reg <= chanSel_next;
      chanWr_reg <= chanWr_next;
      adjOut_reg <= adjVal;
      addValid_reg <= addAdjustCmd;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pulses = pulses_reg;
  assign stepAdjustValue = adjOut_reg;
  assign addAdjustValid = addValid_reg;
  assign adcChannelSelect = chanSel_reg;
  assign adcChannelSelectWr = chanWr_reg;
  assign sequencerEnable = enable_reg;
  assign sequencerStart = start_reg;

endmodule // tsbr_regs

`default_nettype wire

// ---- tsbr_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsbr_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic broadcastCmd,
  input wire logic addAdjustCmd,
  input wire logic controlStepCmd,
  input wire tsbr_pkg::tsbr_pulses_s pulses,
  input wire logic [15:0] stepAdjustValue,
  input wire logic addAdjustValid,
  input wire logic [15:0] adcChannelSelect,
  input wire logic adcChannelSelectWr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_NO_PULSE: assert property (!broadcastCmd |=> pulses == 16'h0000)
    else $error("pulse without broadcast");
  AST_ADD_VLD: assert property (addAdjustCmd |=> addAdjustValid)
    else $error("add strobe missing");
  AST_ADD_QUIET: assert property (!addAdjustCmd |=> !addAdjustValid)
    else $error("stray add strobe");
  AST_STEP_WR: assert property (controlStepCmd |=> adcChannelSelectWr)
    else $error("step write missing");
  AST_STEP_QUIET: assert property (!controlStepCmd |=> !adcChannelSelectWr)
    else $error("stray step write");
  AST_CHAN_HOLD: assert property (!adcChannelSelectWr |-> $stable(adcChannelSelect))
    else $error("channel select moved");
  AST_RDY: assert property (psel && penable && !pready |=> pready)
    else $error("no ready");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_RESET: assert property ($fell(sys_rst) |-> pulses == 16'h0000
    && stepAdjustValue == 16'h0000 && adcChannelSelect == 16'h0000)
    else $error("outputs not cleared");
endmodule // tsbr_checker
bind tsbr_regs tsbr_checker chk_u (.clk, .sys_rst, .psel, .penable, .pready,
  .broadcastCmd, .addAdjustCmd, .controlStepCmd, .pulses, .stepAdjustValue,
  .addAdjustValid, .adcChannelSelect, .adcChannelSelectWr);
`default_nettype wire

// ---- tsbr_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Channel select as the converter latches it on the write strobe
module tsbr_periph_model (
  input wire logic clk,
  input wire logic [15:0] adcChannelSelect,
  input wire logic adcChannelSelectWr,
  output logic [15:0] chanSeen
);
  always_ff @(posedge clk) begin
    if (adcChannelSelectWr) begin
      chanSeen <= adcChannelSelect;
    end
  end
endmodule // tsbr_periph_model
`default_nettype wire

// ---- tsbr_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module trigger_sequencer_broadcast_regs_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic bCmd = 1'b0, aCmd = 1'b0, sCmd = 1'b0, aVld, sWr, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [31:0] rng = 32'h4EB4FF40;
  logic [15:0] adj, chan, seen, b, a, l;
  logic sEn, sSt;
  tsbr_pkg::tsbr_pulses_s pulses;
  int error_cnt = 0, checks = 0;
  always #25 clk = ~clk;
  tsbr_regs dut_u (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .broadcastCmd(bCmd),
    .addAdjustCmd(aCmd), .controlStepCmd(sCmd), .pulses,
    .stepAdjustValue(adj), .addAdjustValid(aVld), .adcChannelSelect(chan),
    .adcChannelSelectWr(sWr), .sequencerEnable(sEn), .sequencerStart(sSt));
  tsbr_periph_model far_u (.clk, .adcChannelSelect(chan),
    .adcChannelSelectWr(sWr), .chanSeen(seen));
  // ------------------------------
  // Helpers
  // ------------------------------
  function logic [15:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[15:0];
  endfunction
  // Locked registers keep the old word
  function logic [31:0] expect_rd(logic [15:0] o, logic [15:0] n, logic lk);
    return {16'h0000, lk ? o : n};
  endfunction
  task chk(input logic [31:0] v, input logic [31:0] e);
    checks++;
    if (v !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, v, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cmd(input int k);
    @(posedge clk);
    case (k)
      0: bCmd <= 1'b1;
      1: aCmd <= 1'b1;
      default: sCmd <= 1'b1;
    endcase
    @(posedge clk);
    {bCmd, aCmd, sCmd} <= 3'b000;
    #1;
  endtask
  task give_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h00000000);
      chk(rd, 32'h00000000);
    end
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : rnd();
      a = rnd();
      l = rnd();
      apb(1'b1, 12'h000, {rnd(), b});
      apb(1'b1, 12'h004, {16'hFFFF, a});
      apb(1'b1, 12'h008, {16'h0000, l});
      apb(1'b0, 12'h000, 32'h00000000);
      chk(rd, {16'h0000, b});
      cmd(0);
      chk(pulses, b);
      @(posedge clk);
      #1 chk(pulses, 32'h00000000);
      cmd(1);
      chk({aVld, adj}, {1'b1, a});
      cmd(2);
      chk({sWr, chan}, {1'b1, l});
      @(posedge clk);
      #1 chk(seen, l);
      $display("broadcast pass %0d done", i);
    end
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, 12'h00C, j ? 32'h1 : 32'h3);
      apb(1'b0, 12'h00C, 32'h00000000);
      chk(rd, j ? 32'h1 : 32'h3);
      chk({30'h0, sSt, sEn}, j ? 32'h1 : 32'h3);
      apb(1'b1, 12'h004, {16'h0000, ~a});
      apb(1'b0, 12'h004, 32'h00000000);
      chk(rd, expect_rd(a, ~a, j == 0));
    end
    apb(1'b0, 12'h010, 32'h00000000);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h00000000);
    $display("lock and unmapped done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h004, 32'h00000000);
    chk(rd, 32'h00000000);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule // trigger_sequencer_broadcast_regs_bench
`default_nettype wire
